/* design/sdrive_startup.sv */
/*
   Start-up, auto-baud and command gate of a serial storage module.
   Assumes rx is an asynchronous pin and rstn covers power-up and the reset pin.
*/
`timescale 1ns/1ps
`include "sdrive_map.svh"

module sdrive_startup #(
   parameter int CW = 24,
   parameter int SETTLE_CYC = `SD_SETTLE_MS * (`SD_CLK_HZ / 1000),
   parameter int GUARD_CYC = `SD_GUARD_MS * (`SD_CLK_HZ / 1000),
   parameter int MAX_PER = `SD_CLK_HZ / `SD_BAUD_MIN,
   parameter int MIN_PER = `SD_CLK_HZ / `SD_BAUD_MAX
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic rx,
   input wire logic fat16_fmt,
   input wire logic [`SD_SECT_AW-1:0] fat_sectors,
   input wire logic [`SD_SECT_AW-1:0] raw_sectors,
   input wire sdrive_pkg::raw_req_s raw_req,
   output logic tx,
   output logic settle_done,
   output logic link_ready,
   output logic lock_err,
   output logic [CW-1:0] bit_period,
   output sdrive_pkg::cmd_s cmd,
   output logic file_ops_ok,
   output logic cfg_reload_ok,
   output logic [`SD_LOC_W-1:0] raw_loc,
   output logic [`SD_SECT_AW:0] capacity
);

   // Refuses period ranges, counter widths and start-up times that the counters cannot serve.
   if (MIN_PER < 4 || MIN_PER > MAX_PER || (MAX_PER << `SD_EDGE_SHIFT) >= (1 << CW) || GUARD_CYC < 1 ||
      SETTLE_CYC < 1)
   begin : g_param_chk
      $error("sdrive_startup: unsupported parameters");
   end

   // Receive pin synchroniser and previous sample for edge detection.
   logic rx_meta_q, rx_sync_q, rx_prev_q;
   logic fall, edge_seen;

   // Bring-up state.
   sdrive_pkg::link_e st_q, st_d;
   logic [31:0] guard_q, guard_d;   // Cycles since reset, up to the guard time.
   logic [31:0] settle_q, settle_d; // Cycles since reset, up to the settle time.
   logic settle_done_q, settle_done_d;
   logic [CW-1:0] cnt_q, cnt_d;     // General interval counter.
   logic [3:0] edge_q, edge_d;      // Edges seen in the auto-baud character.
   logic [CW-1:0] div_q, div_d;     // Locked bit period in cycles.
   logic [CW-1:0] per_w;            // Measured period at the last timed edge.
   logic per_ok;
   logic ready_q, ready_d;
   logic err_q, err_d;
   logic ack_start_q, ack_start_d;
   logic tx_busy;

   // Byte receiver state.
   sdrive_pkg::rx_e rs_q, rs_d;
   logic [CW-1:0] rcnt_q, rcnt_d;
   logic [2:0] rbit_q, rbit_d;
   logic [7:0] rsh_q, rsh_d;
   sdrive_pkg::cmd_s cmd_q, cmd_d;

   // Raw access and capacity results.
   logic [`SD_LOC_W-1:0] loc_q, loc_d;
   logic [`SD_SECT_AW:0] cap_q, cap_d;
   logic file_ok_q, file_ok_d;
   logic cfg_ok_q, cfg_ok_d;

   // Converts a sector count or number into a byte offset.
   function automatic logic [`SD_LOC_W-1:0] sect_bytes(input logic [`SD_SECT_AW-1:0] s);
      sect_bytes = {{(`SD_LOC_W-`SD_SECT_AW-`SD_SECT_SHIFT){1'b0}}, s, {`SD_SECT_SHIFT{1'b0}}};
   endfunction : sect_bytes

   // Two flops before any logic looks at the pin, then an edge sample.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end
      else
      begin
         rx_meta_q <= rx;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   assign fall = rx_prev_q & ~rx_sync_q;
   assign edge_seen = rx_prev_q ^ rx_sync_q;
   // Eight edges after the start fall span eight bit times.  see [RULE_16]
   assign per_w = cnt_q >> `SD_EDGE_SHIFT;
   assign per_ok = (per_w >= CW'(MIN_PER)) && (per_w <= CW'(MAX_PER)); // see [RULE_14]

   // Bring-up sequence: guard, arm, time the 0x55 edges, acknowledge, run.
   always_comb
   begin
      st_d = st_q;
      guard_d = guard_q;
      settle_d = settle_q;
      settle_done_d = settle_done_q;
      cnt_d = cnt_q;
      edge_d = edge_q;
      div_d = div_q;
      ready_d = ready_q;
      err_d = 1'b0;
      ack_start_d = 1'b0;
      // The settle flag tells the host side when talking is allowed.  see [RULE_01]
      if (!settle_done_q)
      begin
         if (settle_q == 32'(SETTLE_CYC - 1)) settle_done_d = 1'b1;
         else settle_d = settle_q + 32'h1;
      end
      unique case (st_q)
         sdrive_pkg::ST_GUARD:
         begin
            // The pin is ignored until the guard time ends.  see [RULE_04]
            if (guard_q == 32'(GUARD_CYC - 1)) st_d = sdrive_pkg::ST_ARMED;
            else guard_d = guard_q + 32'h1;
         end
         sdrive_pkg::ST_ARMED:
         begin
            // Any low level now counts as the auto-baud start bit.  see [RULE_04]
            if (!rx_sync_q)
            begin
               cnt_d = CW'(1);
               edge_d = 4'h0;
               st_d = sdrive_pkg::ST_MEASURE;
            end
         end
         sdrive_pkg::ST_MEASURE:
         begin
            cnt_d = cnt_q + 1'b1;
            if (edge_seen)
            begin
               edge_d = edge_q + 4'h1;
               if (edge_q == `SD_EDGES - 4'h1)
               begin
                  cnt_d = '0;
                  if (per_ok)
                  begin
                     div_d = per_w;
                     st_d = sdrive_pkg::ST_STOPWAIT;
                  end
                  else
                  begin
                     err_d = 1'b1; // see [RULE_16]
                     st_d = sdrive_pkg::ST_REJECT;
                  end
               end
            end
            else if (cnt_q >= CW'(MAX_PER << `SD_EDGE_SHIFT))
            begin
               // No eighth edge within eight slowest bit times of the start fall aborts the lock.  see [RULE_16]
               err_d = 1'b1;
               cnt_d = '0;
               st_d = sdrive_pkg::ST_REJECT;
            end
         end
         sdrive_pkg::ST_STOPWAIT:
         begin
            // Let the last data bit and the stop bit pass before answering.
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == {div_q[CW-2:0], 1'b0})
            begin
               ack_start_d = 1'b1; // see [RULE_12]
               st_d = sdrive_pkg::ST_ACK;
            end
         end
         sdrive_pkg::ST_ACK:
         begin
            // Commands open only once the acknowledge has left.  see [RULE_06]
            if (!ack_start_q && !tx_busy)
            begin
               ready_d = 1'b1;
               st_d = sdrive_pkg::ST_RUN;
            end
         end
         sdrive_pkg::ST_RUN:
         begin
            ready_d = 1'b1;
         end
         sdrive_pkg::ST_REJECT:
         begin
            // Re-arm only after one slowest bit time of idle line.
            cnt_d = rx_sync_q ? cnt_q + 1'b1 : '0;
            if (cnt_q == CW'(MAX_PER)) st_d = sdrive_pkg::ST_ARMED;
         end
         default:
         begin
            st_d = sdrive_pkg::ST_GUARD;
         end
      endcase
   end

   // Registers the bring-up state; reset drops any previous lock.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         st_q <= sdrive_pkg::ST_GUARD; // see [RULE_15]
         guard_q <= 32'h0;
         settle_q <= 32'h0;
         settle_done_q <= 1'b0;
         cnt_q <= '0;
         edge_q <= 4'h0;
         div_q <= '0; // see [RULE_14]
         ready_q <= 1'b0;
         err_q <= 1'b0;
         ack_start_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         guard_q <= guard_d;
         settle_q <= settle_d;
         settle_done_q <= settle_done_d;
         cnt_q <= cnt_d;
         edge_q <= edge_d;
         div_q <= div_d;
         ready_q <= ready_d;
         err_q <= err_d;
         ack_start_q <= ack_start_d;
      end
   end

   // Acknowledge transmitter running at the locked period.
   ack_tx #(.CW(CW)) u_ack_tx (
      .clk(clk),
      .rstn(rstn),
      .start(ack_start_q),
      .data(`SD_ACK_BYTE),
      .div(div_q),
      .tx(tx),
      .busy(tx_busy)
   );

   // Receives 8N1 command bytes once the link is ready; earlier bytes are dropped.
   always_comb
   begin
      rs_d = rs_q;
      rcnt_d = rcnt_q;
      rbit_d = rbit_q;
      rsh_d = rsh_q;
      cmd_d = '0;
      cmd_d.data = cmd_q.data;
      unique case (rs_q)
         sdrive_pkg::RX_IDLE:
         begin
            if (ready_q && fall) // see [RULE_15]
            begin
               rcnt_d = div_q >> 1;
               rs_d = sdrive_pkg::RX_START;
            end
         end
         sdrive_pkg::RX_START:
         begin
            if (rcnt_q != '0) rcnt_d = rcnt_q - 1'b1;
            else if (rx_sync_q) rs_d = sdrive_pkg::RX_IDLE;
            else
            begin
               rcnt_d = div_q - 1'b1;
               rbit_d = 3'h0;
               rs_d = sdrive_pkg::RX_DATA;
            end
         end
         sdrive_pkg::RX_DATA:
         begin
            if (rcnt_q != '0) rcnt_d = rcnt_q - 1'b1;
            else
            begin
               rsh_d = {rx_sync_q, rsh_q[7:1]};
               rcnt_d = div_q - 1'b1;
               rbit_d = rbit_q + 3'h1;
               if (rbit_q == `SD_LAST_BIT) rs_d = sdrive_pkg::RX_STOP;
            end
         end
         sdrive_pkg::RX_STOP:
         begin
            if (rcnt_q != '0) rcnt_d = rcnt_q - 1'b1;
            else
            begin
               // One stop bit, no parity; a low stop bit drops the byte.  see [RULE_13]
               if (rx_sync_q)
               begin
                  cmd_d.valid = 1'b1; // see [RULE_06]
                  cmd_d.data = rsh_q;
               end
               rs_d = sdrive_pkg::RX_IDLE;
            end
         end
      endcase
   end

   // Registers the receiver state.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rs_q <= sdrive_pkg::RX_IDLE;
         rcnt_q <= '0;
         rbit_q <= 3'h0;
         rsh_q <= 8'h00;
         cmd_q <= '0;
      end
      else
      begin
         rs_q <= rs_d;
         rcnt_q <= rcnt_d;
         rbit_q <= rbit_d;
         rsh_q <= rsh_d;
         cmd_q <= cmd_d;
      end
   end

   // Raw location, capacity and access permissions.
   always_comb
   begin
      // Raw space sits after the file partition.  see [RULE_09]
      loc_d = sect_bytes(fat_sectors);
      if (raw_req.is_sector) loc_d = loc_d + sect_bytes(raw_req.sector); // see [RULE_08]
      else loc_d = loc_d + {{(`SD_LOC_W-`SD_BYTE_AW){1'b0}}, raw_req.byte_addr}; // see [RULE_07]
      cap_d = {1'b0, fat_sectors} + {1'b0, raw_sectors}; // see [RULE_09]
      file_ok_d = ready_q & fat16_fmt; // see [RULE_10]
      cfg_ok_d = ready_q; // see [RULE_11]
   end

   // Registers the raw access results.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         loc_q <= '0;
         cap_q <= '0;
         file_ok_q <= 1'b0;
         cfg_ok_q <= 1'b0;
      end
      else
      begin
         loc_q <= loc_d;
         cap_q <= cap_d;
         file_ok_q <= file_ok_d;
         cfg_ok_q <= cfg_ok_d;
      end
   end

   assign settle_done = settle_done_q;
   assign link_ready = ready_q;
   assign lock_err = err_q;
   assign bit_period = div_q;
   assign cmd = cmd_q;
   assign file_ops_ok = file_ok_q;
   assign cfg_reload_ok = cfg_ok_q;
   assign raw_loc = loc_q;
   assign capacity = cap_q;

   // End of the eighth timed edge of the auto-baud character.
   sequence meas_end_s;
      st_q == sdrive_pkg::ST_MEASURE && edge_seen && edge_q == `SD_EDGES - 4'h1;
   endsequence

   guard_hold_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_04]
      guard_q < 32'(GUARD_CYC - 1) |-> st_q == sdrive_pkg::ST_GUARD) else $error("left guard early");
   settle_time_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_01]
      $rose(settle_done_q) |-> $past(settle_q) == 32'(SETTLE_CYC - 1)) else $error("settle time wrong");
   reset_clear_a: assert property (@(posedge clk) // see [RULE_15]
      !rstn |=> st_q == sdrive_pkg::ST_GUARD && !ready_q && div_q == '0) else $error("reset kept lock");
   cmd_gate_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_06]
      cmd_q.valid |-> ready_q) else $error("command before acknowledge");
   ack_send_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_12]
      ack_start_q |=> tx_busy ##1 !tx) else $error("acknowledge not started");
   ready_order_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_06]
      $rose(ready_q) |-> $past(st_q) == sdrive_pkg::ST_ACK && !tx_busy) else $error("ready before ack");
   lock_range_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_14]
      ready_q |-> div_q >= CW'(MIN_PER) && div_q <= CW'(MAX_PER)) else $error("period out of range");
   reject_bad_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_16]
      meas_end_s ##0 !per_ok |=> st_q == sdrive_pkg::ST_REJECT && err_q) else $error("bad period accepted");
   lock_value_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_16]
      meas_end_s ##0 per_ok |=> div_q == $past(per_w)) else $error("period not stored");
   raw_sector_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_08]
      raw_req.is_sector |=> raw_loc == sect_bytes($past(fat_sectors)) + sect_bytes($past(raw_req.sector)))
      else $error("sector location wrong");

endmodule : sdrive_startup

/* design/sdrive_map.svh */
/*
   Constants of the serial storage start-up and auto-baud block.
   Assumes a 200 MHz core clock and a host that follows the start-up order.
*/
// Function
// [RULE_01] Settle up to 500 ms after any reset.
// [RULE_02] Host ignores transmit line while settling.
// [RULE_03] Host drives receive line high within 100 ms.
// [RULE_04] After 100 ms, any low starts auto-baud.
// [RULE_05] First host byte is auto-baud character 0x55.
// [RULE_06] Commands accepted only after acknowledge sent.
// [RULE_07] Raw byte access uses 32-bit address.
// [RULE_08] Raw sector access: 24-bit number, 512 bytes.
// [RULE_09] File partition first, raw follows, sizes add.
// [RULE_10] File operations need 16-bit allocation format.
// [RULE_11] Configuration image reloads only over serial.
// [RULE_12] Acknowledge byte after lock is 0x06.
// [RULE_13] Frames: eight data bits, no parity, one stop.
// [RULE_14] Lock 300 to 256K baud, every reset.
// [RULE_15] Reset discards lock, returns to settle-detect.
// [RULE_16] Time alternating edges, reject out-of-range periods.
`ifndef SDRIVE_MAP_SVH
`define SDRIVE_MAP_SVH

// Core clock rate in hertz.
`define SD_CLK_HZ 200000000
// Settle and input guard times in milliseconds.
`define SD_SETTLE_MS 500
`define SD_GUARD_MS 100
// Supported baud range.
`define SD_BAUD_MIN 300
`define SD_BAUD_MAX 256000
// Auto-baud and acknowledge byte values.
`define SD_AUTOBAUD_CHAR 8'h55
`define SD_ACK_BYTE 8'h06
// Edges timed after the start fall, and the matching shift.
`define SD_EDGES 4'h8
`define SD_EDGE_SHIFT 3
// Bits in one frame: start, eight data, stop.
`define SD_FRAME_BITS 4'ha
// Data bits per frame and the index of the last one.
`define SD_DATA_BITS 8
`define SD_LAST_BIT 3'h7
// Raw address widths and the sector size as a shift.
`define SD_BYTE_AW 32
`define SD_SECT_AW 24
`define SD_SECT_SHIFT 9
`define SD_LOC_W 34

`endif

/* design/sdrive_pkg.sv */
/*
   Types of the serial storage start-up and auto-baud block.
   Assumes sdrive_map.svh defines the widths used here.
*/
`include "sdrive_map.svh"

package sdrive_pkg;

   // Link bring-up states.
   typedef enum logic [2:0]
   {
      ST_GUARD = 3'b000,
      ST_ARMED = 3'b001,
      ST_MEASURE = 3'b010,
      ST_STOPWAIT = 3'b011,
      ST_ACK = 3'b100,
      ST_RUN = 3'b101,
      ST_REJECT = 3'b110
   } link_e;

   // Byte receiver states.
   typedef enum logic [1:0]
   {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_e;

   // One received command byte with its strobe.
   typedef struct packed
   {
      logic valid;
      logic [7:0] data;
   } cmd_s;

   // A raw access request: byte address or sector number.
   typedef struct packed
   {
      logic is_sector;
      logic [`SD_BYTE_AW-1:0] byte_addr;
      logic [`SD_SECT_AW-1:0] sector;
   } raw_req_s;

endpackage : sdrive_pkg

/* design/ack_tx.sv */
/*
   Serial transmitter for one 8N1 byte at a given bit period.
   Assumes div is stable while busy and at least 2.
*/
`timescale 1ns/1ps
`include "sdrive_map.svh"

module ack_tx #(
   parameter int CW = 24
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [7:0] data,
   input wire logic [CW-1:0] div,
   output logic tx,
   output logic busy
);

   // Refuses a counter too narrow for the shortest useful period.
   if (CW < 10)
   begin : g_cw_chk
      $error("ack_tx: counter too narrow");
   end

   logic [9:0] sh_q, sh_d;     // Remaining frame bits, LSB goes out next.
   logic [3:0] left_q, left_d; // Bits still to send.
   logic [CW-1:0] cnt_q, cnt_d; // Cycles left in the current bit.
   logic tx_q, tx_d;
   logic busy_q, busy_d;

   // Loads a frame on start and shifts one bit per period.
   always_comb
   begin
      sh_d = sh_q;
      left_d = left_q;
      cnt_d = cnt_q;
      tx_d = tx_q;
      busy_d = busy_q;
      if (!busy_q)
      begin
         tx_d = 1'b1;
         if (start)
         begin
            // Stop bit, data, start bit: no parity.  see [RULE_13]
            sh_d = {1'b1, data, 1'b0};
            left_d = `SD_FRAME_BITS;
            cnt_d = '0;
            busy_d = 1'b1;
         end
      end
      else if (cnt_q == '0)
      begin
         if (left_q == 4'h0)
         begin
            busy_d = 1'b0;
            tx_d = 1'b1;
         end
         else
         begin
            tx_d = sh_q[0];
            sh_d = {1'b1, sh_q[9:1]};
            left_d = left_q - 4'h1;
            cnt_d = div - 1'b1;
         end
      end
      else
      begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Registers the transmitter state.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sh_q <= 10'h3ff;
         left_q <= 4'h0;
         cnt_q <= '0;
         tx_q <= 1'b1;
         busy_q <= 1'b0;
      end
      else
      begin
         sh_q <= sh_d;
         left_q <= left_d;
         cnt_q <= cnt_d;
         tx_q <= tx_d;
         busy_q <= busy_d;
      end
   end

   assign tx = tx_q;
   assign busy = busy_q;

   // The line idles high whenever no frame is in flight.
   idle_high_a: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_13]
      !busy_q |=> tx_q) else $error("tx not high while idle");

endmodule : ack_tx

/* test/host_model.sv */
/*
   Host side of the serial link: sends 8N1 bytes on the device receive pin and decodes device replies.
   Assumes the bench calls send_byte between negative clock edges and drives the device reset.
*/
`timescale 1ns/1ps

module host_model #(
   parameter int MUTE = 200
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tx,
   output logic rx
);
   int per = 800; // Bit period in clock cycles of the current rate.
   int quiet = 0; // Cycles since the device left reset, up to MUTE.
   int n_got = 0; // Count of bytes decoded from the device.
   logic [7:0] r; // Byte being assembled.
   logic [7:0] got = 8'h00; // Last byte decoded.
   logic stop = 1'b0; // Stop bit level of the last byte.

   // The line idles high from time zero, so no false start bit is seen.
   initial rx = 1'b1;

   // Sends one byte LSB first with one start and one stop bit.
   task automatic send_byte(input logic [7:0] b, input int p);
      per = p;
      @(negedge clk);
      rx <= 1'b0;
      repeat (p) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
         rx <= b[i];
         repeat (p) @(negedge clk);
      end
      rx <= 1'b1;
      repeat (p) @(negedge clk);
   endtask : send_byte

   // Pulls the line low for n cycles, as a host that wakes slowly would.
   task automatic pulse_low(input int n);
      rx <= 1'b0;
      repeat (n) @(negedge clk);
      rx <= 1'b1;
   endtask : pulse_low

   // Counts the settle time after reset; replies are ignored until it ends.
   always @(posedge clk)
   begin
      if (rstn !== 1'b1)
         quiet <= 0;
      else if (quiet < MUTE)
         quiet <= quiet + 1;
   end

   // Decodes device bytes once the settle time is over.
   always
   begin
      @(posedge clk);
      if (quiet >= MUTE && tx === 1'b0)
      begin
         repeat (per / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (per) @(posedge clk);
            r[i] = tx;
         end
         repeat (per) @(posedge clk);
         stop = tx;
         got = r;
         n_got++;
      end
   end
endmodule : host_model

/* test/sdrive_startup_tb.sv */
/*
   Self-checking bench of the start-up and auto-baud block with a host model on the link.
   Assumes shortened settle, guard and slowest-period counts; inputs change at falling edges.
*/
`timescale 1ns/1ps
`include "sdrive_map.svh"

module sdrive_startup_tb;
   localparam int SETTLE = 200; // Shortened settle count.
   localparam int GUARD = 100; // Shortened input guard count.
   localparam int MAXP = 1000; // Shortened slowest bit period.
   localparam int P1 = 800; // Fast rate near the top limit.
   localparam int P2 = 1000; // Second rate for the relock, right at the slowest limit.
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic rx, tx, fat16_fmt, settle_done, link_ready, lock_err, file_ops_ok, cfg_reload_ok;
   logic [23:0] fat_sectors, raw_sectors, bit_period;
   logic [33:0] raw_loc;
   logic [24:0] capacity;
   sdrive_pkg::raw_req_s raw_req;
   sdrive_pkg::cmd_s cmd;
   logic [7:0] last_cmd = 8'h00; // Last command byte passed on.
   int err_total = 0;
   int n_compared = 0;
   int n_cmd = 0; // Command strobes seen.
   int n_lockerr = 0; // Lock error pulses seen.

   // A 200 MHz clock.
   always #2.5 clk = ~clk;

   sdrive_startup #(.SETTLE_CYC(SETTLE), .GUARD_CYC(GUARD), .MAX_PER(MAXP)) sdrive_startup_inst (
      .clk(clk), .rstn(rstn), .rx(rx), .fat16_fmt(fat16_fmt), .fat_sectors(fat_sectors),
      .raw_sectors(raw_sectors), .raw_req(raw_req), .tx(tx), .settle_done(settle_done),
      .link_ready(link_ready), .lock_err(lock_err), .bit_period(bit_period), .cmd(cmd),
      .file_ops_ok(file_ops_ok), .cfg_reload_ok(cfg_reload_ok), .raw_loc(raw_loc), .capacity(capacity));

   host_model #(.MUTE(SETTLE)) host_model_inst (.clk(clk), .rstn(rstn), .tx(tx), .rx(rx));

   // Counts one-cycle strobes of the device outputs.
   always @(posedge clk)
   begin
      if (cmd.valid === 1'b1)
      begin
         last_cmd <= cmd.data;
         n_cmd <= n_cmd + 1;
      end
      if (lock_err === 1'b1)
         n_lockerr <= n_lockerr + 1;
   end

   // Compares a value.
   task automatic chk_val(input string what, input logic [39:0] exp, input logic [39:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   // Compares a flag.
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_val(what, {39'h0, exp}, {39'h0, got});
   endtask : chk_bit

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   // Holds reset for five cycles, then checks the cleared outputs.
   task automatic do_reset;
      @(negedge clk);
      rstn <= 1'b0;
      repeat (5) @(negedge clk);
      chk_bit("settle flag", 1'b0, settle_done);
      chk_bit("link flag", 1'b0, link_ready);
      chk_val("period", 40'h0, bit_period);
      chk_bit("tx idle", 1'b1, tx);
      chk_bit("reload flag", 1'b0, cfg_reload_ok);
      rstn <= 1'b1;
   endtask : do_reset

   // Sends the auto-baud character and expects the acknowledge and the lock.
   task automatic lock_at(input int p);
      int n0;
      int c0;
      int k;
      n0 = host_model_inst.n_got;
      c0 = n_cmd;
      host_model_inst.send_byte(`SD_AUTOBAUD_CHAR, p);
      k = 0;
      while (link_ready !== 1'b1 && k < 20 * p)
      begin
         @(negedge clk);
         k++;
      end
      chk_bit("lock in time", 1'b1, k < 20 * p);
      if (k >= 20 * p) test_done();
      chk_val("ack", `SD_ACK_BYTE, host_model_inst.got);
      chk_bit("ack stop", 1'b1, host_model_inst.stop);
      chk_val("ack count", n0 + 1, host_model_inst.n_got);
      chk_val("period", p, bit_period);
      chk_val("no early cmd", c0, n_cmd);
   endtask : lock_at

   // Settle flag rises after the settle count.
   task automatic t_settle;
      int k;
      do_reset();
      k = 0;
      while (settle_done !== 1'b1 && k < SETTLE + 50)
      begin
         @(negedge clk);
         k++;
      end
      chk_bit("settle time", 1'b1, k >= SETTLE - 2 && k <= SETTLE + 4);
      if (k >= SETTLE + 50) test_done();
      $display("settle test done");
   endtask : t_settle

   // Lock, then two back-to-back command bytes.
   task automatic t_lock_cmd;
      int c0;
      lock_at(P1);
      c0 = n_cmd;
      host_model_inst.send_byte(8'ha3, P1);
      chk_val("cmd 1", 8'ha3, last_cmd);
      host_model_inst.send_byte(8'h5c, P1);
      chk_val("cmd 2", 8'h5c, last_cmd);
      chk_val("cmd count", c0 + 2, n_cmd);
      $display("lock and command test done");
   endtask : t_lock_cmd

   // Raw locations at the widest address, capacity and status flags.
   task automatic t_raw;
      fat_sectors <= 24'h000010;
      raw_sectors <= 24'hffffff;
      raw_req <= '{1'b0, 32'hffffffff, 24'h000000};
      repeat (2) @(negedge clk);
      chk_val("byte loc", 34'h100001fff, raw_loc);
      chk_val("capacity", 25'h100000f, capacity);
      chk_bit("file ops", 1'b1, file_ops_ok);
      chk_bit("reload", 1'b1, cfg_reload_ok);
      raw_req <= '{1'b1, 32'h00000000, 24'hffffff};
      fat16_fmt <= 1'b0;
      repeat (2) @(negedge clk);
      chk_val("sector loc", 34'h200001e00, raw_loc);
      chk_bit("file ops off", 1'b0, file_ops_ok);
      fat16_fmt <= 1'b1;
      $display("raw test done");
   endtask : t_raw

   // Reset in mid-run, a low glitch inside the guard, then a lock at a new rate.
   task automatic t_relock;
      int e0;
      e0 = n_lockerr;
      do_reset();
      repeat (10) @(negedge clk);
      host_model_inst.pulse_low(50);
      // The host still waits out the settle time before the auto-baud character.
      repeat (SETTLE - 50) @(negedge clk);
      lock_at(P2);
      chk_val("no lock error", e0, n_lockerr);
      $display("relock test done");
   endtask : t_relock

   // A rate above the top limit is refused; the line recovers after idle.
   task automatic t_reject;
      int e0;
      do_reset();
      repeat (SETTLE + 5) @(negedge clk);
      e0 = n_lockerr;
      host_model_inst.send_byte(`SD_AUTOBAUD_CHAR, 400);
      repeat (10) @(negedge clk);
      chk_val("lock error", e0 + 1, n_lockerr);
      chk_bit("no lock", 1'b0, link_ready);
      repeat (MAXP + 200) @(negedge clk);
      // A start bit held 20 cycles past eight slowest bit times has no eighth edge in time and is refused too.
      host_model_inst.pulse_low(8 * MAXP + 20);
      repeat (MAXP + 200) @(negedge clk);
      chk_val("edge timeout", e0 + 2, n_lockerr);
      chk_bit("still no lock", 1'b0, link_ready);
      lock_at(P1);
      $display("reject test done");
   endtask : t_reject

   // Main sequence.
   initial
   begin
      fat16_fmt = 1'b1;
      fat_sectors = 24'h000000;
      raw_sectors = 24'h000000;
      raw_req = '0;
      t_settle();
      t_lock_cmd();
      t_raw();
      t_relock();
      t_reject();
      test_done();
   end

   // Cuts a hang short.
   initial
   begin
      repeat (95000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule : sdrive_startup_tb
